//--- verilog/oser_pkg.sv
// Package for the output stage enable register bank
package oser_pkg;
    // Printed register offsets are not all multiples of four: they are word indices
    localparam logic [7:0] IDX_HP = 8'h5a;
    localparam logic [7:0] IDX_LINE = 8'h5e;
    localparam logic [7:0] IDX_PUMP = 8'h62;
    localparam logic [7:0] IDX_PWR = 8'h68;
    localparam logic [7:0] IDX_SEQ0 = 8'h6c;
    localparam logic [7:0] IDX_SEQ1 = 8'h6d;
    // Writable bit masks of each register
    localparam logic [15:0] MASK_HP = 16'h001f;
    localparam logic [15:0] MASK_LINE = 16'h00ff;
    localparam logic [15:0] MASK_PUMP = 16'h0001;
    localparam logic [15:0] MASK_PWR = 16'h0001;
    localparam logic [15:0] MASK_SEQ0 = 16'h011f;
    localparam logic [15:0] MASK_SEQ1 = 16'h7fff;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    // Field positions
    localparam int HP_IN = 0;
    localparam int HP_MID = 1;
    localparam int HP_OUT = 2;
    localparam int HP_SHORT = 3;
    localparam int HPL_IN = 4;
    localparam int LR_BASE = 0;
    localparam int LL_BASE = 4;
    localparam int SEQ_CLK = 8;
    localparam int IDX_LSB = 0;
    localparam int IDX_W = 5;
    localparam int ADR_LSB = 0;
    localparam int POS_LSB = 8;
    localparam int WID_LSB = 12;
    // Ordering advice for software
    localparam int MID_DELAY_US = 20;
    // One driver's four stage controls
    typedef struct packed {
        logic short_release;
        logic output_stage_en;
        logic middle_stage_en;
        logic input_stage_en;
    } oser_drv_t;
    // One sequencer step definition as stored
    typedef struct packed {
        logic [2:0] step_field_width;
        logic [3:0] step_field_lsb_pos;
        logic [7:0] step_target_address;
    } oser_step_t;
endpackage

//--- verilog/oser_regs.sv
// Output stage enable registers with APB slave and step store
//
// Notes on behaviour
// - Left phones input stage enabled first
// - Bit3 releases right phones short, set last
// - Bit2 right phones output stage, after offset
// - Bit1 right phones middle stage, 20us later
// - Bit0 right phones input stage, set first
// - Bit7 releases left line short, last
// - Bit6 left line output stage enable
// - Bit5 left line middle stage, 20us later
// - Bit4 left line input stage, first
// - Bit3 releases right line short, last
// - Bit2 right line output stage enable
// - Bit1 right line middle stage, 20us later
// - Bit0 right line input stage, first
// - Bit0 pump enable, resets to zero
// - Bit0 selects pump level tracking source
// - Bit8 gates sequencer clock, reset off
// - Five bit index selects store entry
// - Bits14:12 width code, width is code+1
// - Bits11:8 field lsb position
// - Bits7:0 step target address
`timescale 1ns/1ps
module oser_regs #(
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_left_phones_input_stage_en,
    output oser_pkg::oser_drv_t o_right_phones,
    output oser_pkg::oser_drv_t o_left_line,
    output oser_pkg::oser_drv_t o_right_line,
    output logic o_pump_enable,
    output logic o_pump_level_tracking,
    output logic o_seq_detect_clock_gate,
    output logic [4:0] o_step_store_index,
    input wire logic [4:0] i_step_read_index,
    output oser_pkg::oser_step_t o_step_read
);
    // ==========================================================
    // Elaboration checks
    if (DEPTH != 32) begin : g_bad_depth
        $error("DEPTH must be 32 to match the five bit index");
    end

    // ==========================================================
    // Registers
    logic [15:0] hp;
    logic [15:0] line;
    logic [15:0] pump;
    logic [15:0] pwr;
    logic [15:0] seq0;
    logic [15:0] seq1;
    oser_pkg::oser_step_t store [DEPTH];

    // ==========================================================
    // APB decode
    logic wr_en;
    logic acc;
    logic [7:0] idx;
    logic mapped;
    logic [15:0] wdata;
    logic [15:0] rdata;

    // Word index from byte address; single cycle access
    assign idx = i_paddr[9:2];
    assign acc = i_psel && i_penable;
    assign mapped = (i_paddr[31:10] == 22'h00_0000) && (i_paddr[1:0] == 2'b00) &&
        (idx == oser_pkg::IDX_HP || idx == oser_pkg::IDX_LINE ||
         idx == oser_pkg::IDX_PUMP || idx == oser_pkg::IDX_PWR ||
         idx == oser_pkg::IDX_SEQ0 || idx == oser_pkg::IDX_SEQ1);
    assign wr_en = acc && i_pwrite && mapped;
    assign o_pready = 1'b1;
    assign o_pslverr = acc && !mapped;

    // Byte strobes merge into the old value
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
        logic [15:0] v;
        v = old;
        if (i_pstrb[0]) begin
            v[7:0] = i_pwdata[7:0];
        end
        if (i_pstrb[1]) begin
            v[15:8] = i_pwdata[15:8];
        end
        return v & msk;
    endfunction

    // Headphone stage bits, written straight to the outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hp <= oser_pkg::RST_ZERO;
        end else if (wr_en && idx == oser_pkg::IDX_HP) begin
            hp <= merge(hp, oser_pkg::MASK_HP);
        end
    end

    // Line output stage bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            line <= oser_pkg::RST_ZERO;
        end else if (wr_en && idx == oser_pkg::IDX_LINE) begin
            line <= merge(line, oser_pkg::MASK_LINE);
        end
    end

    // Charge pump enable and power mode
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pump <= oser_pkg::RST_ZERO;
            pwr <= oser_pkg::RST_ZERO;
        end else if (wr_en && idx == oser_pkg::IDX_PUMP) begin
            pump <= merge(pump, oser_pkg::MASK_PUMP);
        end else if (wr_en && idx == oser_pkg::IDX_PWR) begin
            pwr <= merge(pwr, oser_pkg::MASK_PWR);
        end
    end

    // Sequencer clock gate and write index
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seq0 <= oser_pkg::RST_ZERO;
        end else if (wr_en && idx == oser_pkg::IDX_SEQ0) begin
            seq0 <= merge(seq0, oser_pkg::MASK_SEQ0);
        end
    end

    // Step register mirror
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seq1 <= oser_pkg::RST_ZERO;
        end else if (wr_en && idx == oser_pkg::IDX_SEQ1) begin
            seq1 <= merge(seq1, oser_pkg::MASK_SEQ1);
        end
    end

    // Step store: a step write is copied to the indexed entry
    // The merge reads the bus inputs, so it sits in a combinational process
    // that also wakes on them
    logic [15:0] step_new;
    always_comb begin
        step_new = merge(seq1, oser_pkg::MASK_SEQ1);
    end
    // No reset on the store: entries stay unknown until software fills them
    always_ff @(posedge i_clk) begin
        if (wr_en && idx == oser_pkg::IDX_SEQ1) begin
            store[o_step_store_index] <= oser_pkg::oser_step_t'(step_new[14:0]);
        end
    end

    // Read data select, combinational
    always_comb begin
        rdata = 16'h0000;
        unique case (idx)
            oser_pkg::IDX_HP: rdata = hp;
            oser_pkg::IDX_LINE: rdata = line;
            oser_pkg::IDX_PUMP: rdata = pump;
            oser_pkg::IDX_PWR: rdata = pwr;
            oser_pkg::IDX_SEQ0: rdata = seq0;
            oser_pkg::IDX_SEQ1: rdata = seq1;
            default: rdata = 16'h0000;
        endcase
    end

    // Read data held in flops, loaded at the edge that ends the setup phase
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            // Refused places read as zero even when the index aliases a register
            o_prdata <= mapped ? {16'h0000, rdata} : 32'h0000_0000;
        end
    end

    // Stored step readback for the sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_step_read <= '0;
        end else begin
            o_step_read <= store[i_step_read_index];
        end
    end

    // ==========================================================
    // Outputs straight from the register bits
    assign o_right_phones = hp[oser_pkg::HP_IN +: 4];
    assign o_left_phones_input_stage_en = hp[oser_pkg::HPL_IN];
    assign o_right_line = line[oser_pkg::LR_BASE +: 4];
    assign o_left_line = line[oser_pkg::LL_BASE +: 4];
    assign o_pump_enable = pump[0];
    assign o_pump_level_tracking = pwr[0];
    assign o_seq_detect_clock_gate = seq0[oser_pkg::SEQ_CLK];
    assign o_step_store_index = seq0[oser_pkg::IDX_LSB +: oser_pkg::IDX_W];

    // ==========================================================
    // Assertions
    a_hp_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_HP && i_pstrb[0]) |=>
        o_right_phones == $past(i_pwdata[3:0]))
        else $error("Headphone enables did not follow write");
    a_line_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_LINE && i_pstrb[0]) |=>
        {o_left_line, o_right_line} == $past(i_pwdata[7:0]))
        else $error("Line enables did not follow write");
    a_hp_stable: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_en && idx == oser_pkg::IDX_HP) |=> $stable(o_right_phones))
        else $error("Headphone enables changed without write");
    a_pump_write: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_PUMP && i_pstrb[0]) |=>
        o_pump_enable == $past(i_pwdata[0]))
        else $error("Pump enable wrong");
    a_track_write: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_PWR && i_pstrb[0]) |=>
        o_pump_level_tracking == $past(i_pwdata[0]))
        else $error("Level tracking select wrong");
    a_clk_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_SEQ0 && i_pstrb[1]) |=>
        o_seq_detect_clock_gate == $past(i_pwdata[8]))
        else $error("Sequencer clock gate wrong");
    a_index_write: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_SEQ0 && i_pstrb[0]) |=>
        o_step_store_index == $past(i_pwdata[4:0]))
        else $error("Write index wrong");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (hp[15:5] == 11'h000) && (line[15:8] == 8'h00) && (seq0[15:9] == 7'h00) &&
        (seq0[7:5] == 3'h0) && (seq1[15] == 1'b0))
        else $error("Reserved bits not zero");
    a_step_store: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_SEQ1 && &i_pstrb[1:0] &&
         i_step_read_index == o_step_store_index) ##1
        (i_step_read_index == $past(o_step_store_index)) |=>
        o_step_read == $past(i_pwdata[14:0], 2))
        else $error("Step store entry wrong");

    // Left phones input enable follows its write
    a_lhp_write: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_HP && i_pstrb[0]) |=>
        o_left_phones_input_stage_en == $past(i_pwdata[oser_pkg::HPL_IN]))
        else $error("Left phones input enable did not follow write");

    // Left phones input enable holds between writes
    a_lhp_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_en && idx == oser_pkg::IDX_HP) |=> $stable(o_left_phones_input_stage_en))
        else $error("Left phones input enable changed without write");

    // Line stage enables hold between writes
    a_line_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_en && idx == oser_pkg::IDX_LINE) |=> $stable({o_left_line, o_right_line}))
        else $error("Line enables changed without write");

    // Pump controls hold between writes to their registers
    a_pump_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_en && (idx == oser_pkg::IDX_PUMP || idx == oser_pkg::IDX_PWR)) |=>
        $stable({o_pump_enable, o_pump_level_tracking}))
        else $error("Pump controls changed without write");

    // Sequencer clock gate and write index hold between writes
    a_seq_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_en && idx == oser_pkg::IDX_SEQ0) |=>
        $stable({o_seq_detect_clock_gate, o_step_store_index}))
        else $error("Sequencer setup changed without write");

    // While reset stands every control and read register is cleared
    a_reset_clear: assert property (@(posedge i_clk)
        (i_rst && $past(i_rst)) |->
        (o_right_phones == 4'h0 && o_left_line == 4'h0 && o_right_line == 4'h0 &&
         !o_left_phones_input_stage_en && !o_pump_enable && !o_pump_level_tracking &&
         !o_seq_detect_clock_gate && o_step_store_index == 5'h00 &&
         o_step_read == 15'h0000 && o_prdata == 32'h0000_0000))
        else $error("Outputs not cleared by reset");

    // Misaligned accesses are refused
    a_misalign_err: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && i_penable && i_paddr[1:0] != 2'b00) |-> o_pslverr)
        else $error("Misaligned access not refused");

    // Addresses above the register window are refused
    a_high_err: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && i_penable && i_paddr[31:10] != 22'h00_0000) |-> o_pslverr)
        else $error("Access above register window not refused");

    // The headphone register address is accepted
    a_hp_accept: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && i_penable && i_paddr == {22'h00_0000, oser_pkg::IDX_HP, 2'b00}) |->
        !o_pslverr)
        else $error("Headphone register access refused");

    // A misaligned read is refused and returns zero
    a_refused_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && !i_penable && !i_pwrite && i_paddr[1:0] != 2'b00) |=>
        o_prdata == 32'h0000_0000)
        else $error("Refused read returned data");

    // Headphone readback shows the enables that drive the stages
    a_hp_readback: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && !i_penable && !i_pwrite &&
         i_paddr == {22'h00_0000, oser_pkg::IDX_HP, 2'b00}) |=>
        o_prdata == {27'h000_0000, $past(o_left_phones_input_stage_en), $past(o_right_phones)})
        else $error("Headphone readback differs from outputs");

    // Pump and mode registers keep their upper bits clear
    a_pump_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
        (pump[15:1] == 15'h0000) && (pwr[15:1] == 15'h0000))
        else $error("Pump register reserved bits not zero");

    // The upper half of the read data stays zero
    a_prdata_upper: assert property (@(posedge i_clk) disable iff (i_rst)
        o_prdata[31:16] == 16'h0000)
        else $error("Upper read data not zero");

    // A full step write lands in the readback mirror
    a_step_mirror: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && idx == oser_pkg::IDX_SEQ1 && &i_pstrb[1:0]) |=>
        seq1 == {1'b0, $past(i_pwdata[14:0])})
        else $error("Step register mirror wrong");

    // Each right phones stage bit follows its own data bit
    for (genvar g = oser_pkg::HP_IN; g <= oser_pkg::HP_SHORT; g++) begin : g_hp_bit
        a_hp_bit: assert property (@(posedge i_clk)
            disable iff (i_rst)
            (wr_en && idx == oser_pkg::IDX_HP && i_pstrb[0]) |=> hp[g] == $past(i_pwdata[g]))
            else $error("Headphone stage bit did not follow write");
    end

    // Each right line stage bit follows its own data bit
    for (genvar g = oser_pkg::LR_BASE; g < oser_pkg::LL_BASE; g++) begin : g_rline_bit
        a_rline_bit: assert property (@(posedge i_clk)
            disable iff (i_rst)
            (wr_en && idx == oser_pkg::IDX_LINE && i_pstrb[0]) |=> line[g] == $past(i_pwdata[g]))
            else $error("Right line stage bit did not follow write");
    end

    // Each left line stage bit follows its own data bit
    for (genvar g = oser_pkg::LL_BASE; g < oser_pkg::LL_BASE + 4; g++) begin : g_lline_bit
        a_lline_bit: assert property (@(posedge i_clk)
            disable iff (i_rst)
            (wr_en && idx == oser_pkg::IDX_LINE && i_pstrb[0]) |=> line[g] == $past(i_pwdata[g]))
            else $error("Left line stage bit did not follow write");
    end
endmodule

//--- dv/oser_regs_tb.sv
// Self-checking bench for the output stage enable register bank
`timescale 1ns/1ps
module oser_regs_tb;
    // ==========================================================
    // Signals, model state and the design
    logic i_clk, i_rst, i_psel, i_penable, i_pwrite;
    logic [31:0] i_paddr, i_pwdata, o_prdata;
    logic [3:0] i_pstrb;
    logic o_pready, o_pslverr, o_pump_enable, o_pump_level_tracking, o_seq_detect_clock_gate;
    oser_pkg::oser_drv_t o_right_phones, o_left_line, o_right_line;
    logic o_left_phones_input_stage_en;
    logic [4:0] o_step_store_index, i_step_read_index;
    oser_pkg::oser_step_t o_step_read;
    localparam logic [7:0] IDX [6] = '{oser_pkg::IDX_HP, oser_pkg::IDX_LINE, oser_pkg::IDX_PUMP,
        oser_pkg::IDX_PWR, oser_pkg::IDX_SEQ0, oser_pkg::IDX_SEQ1};
    localparam logic [15:0] MASK [6] = '{oser_pkg::MASK_HP, oser_pkg::MASK_LINE,
        oser_pkg::MASK_PUMP, oser_pkg::MASK_PWR, oser_pkg::MASK_SEQ0, oser_pkg::MASK_SEQ1};
    logic [15:0] exp_reg [6];
    logic [14:0] exp_store [32];
    bit stored [32];
    int err_total = 0;
    int checked = 0;
    int seed = 61;
    localparam int SETTLE = oser_pkg::MID_DELAY_US * 40; // Settling cycles at 40 MHz
    oser_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_left_phones_input_stage_en(o_left_phones_input_stage_en),
        .o_right_phones(o_right_phones), .o_left_line(o_left_line),
        .o_right_line(o_right_line), .o_pump_enable(o_pump_enable),
        .o_pump_level_tracking(o_pump_level_tracking),
        .o_seq_detect_clock_gate(o_seq_detect_clock_gate),
        .o_step_store_index(o_step_store_index), .i_step_read_index(i_step_read_index),
        .o_step_read(o_step_read));
    // 40 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // ==========================================================
    // Bus tasks and comparisons
    task automatic summarize;
        $display("mismatches=%0d comparisons=%0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            err_total++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    // One APB transfer; pready, read data and error are taken at one rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic chk_out;
        chk({31'h0, o_left_phones_input_stage_en}, {31'h0, exp_reg[0][4]});
        chk({28'h0, o_right_phones}, {28'h0, exp_reg[0][3:0]});
        chk({28'h0, o_left_line}, {28'h0, exp_reg[1][7:4]});
        chk({28'h0, o_right_line}, {28'h0, exp_reg[1][3:0]});
        chk({31'h0, o_pump_enable}, {31'h0, exp_reg[2][0]});
        chk({31'h0, o_pump_level_tracking}, {31'h0, exp_reg[3][0]});
        chk({31'h0, o_seq_detect_clock_gate}, {31'h0, exp_reg[4][8]});
        chk({27'h0, o_step_store_index}, {27'h0, exp_reg[4][4:0]});
    endtask
    task automatic wreg(input int k, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] m;
        logic [31:0] r;
        logic e;
        m = MASK[k] & {{8{s[1]}}, {8{s[0]}}};
        apb(1'b1, {22'h0, IDX[k], 2'b00}, {16'hffff, d}, s, r, e);
        exp_reg[k] = (exp_reg[k] & ~m) | (d & m);
        if (k == 5) begin
            exp_store[exp_reg[4][4:0]] = exp_reg[5][14:0];
            stored[exp_reg[4][4:0]] = 1'b1;
        end
        chk({31'h0, e}, 32'h0000_0000);
        @(negedge i_clk);
        chk_out();
    endtask
    task automatic rreg(input int k);
        logic [31:0] r;
        logic e;
        apb(1'b0, {22'h0, IDX[k], 2'b00}, 32'h0000_0000, 4'h0, r, e);
        chk(r, {16'h0, exp_reg[k]});
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        int k;
        i_rst = 1'b1;
        {i_psel, i_penable, i_pwrite} = 3'b000;
        i_paddr = 32'h0000_0000;
        i_pwdata = 32'h0000_0000;
        i_pstrb = 4'h0;
        i_step_read_index = 5'h00;
        for (int j = 0; j < 6; j++) exp_reg[j] = oser_pkg::RST_ZERO;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values of every register
        for (int j = 0; j < 6; j++) rreg(j);
        // Bring-up order, one stage bit at a time, reserved bits beyond; each
        // middle stage waits the settling time after its input stage
        for (int j = 0; j < 2; j++) begin
            for (int b = 0; b < 9; b++) begin
                if (b == 1 || b == 5) repeat (SETTLE) @(posedge i_clk);
                wreg(j, 16'((17'h1 << (b + 1)) - 1), 4'h3);
            end
        end
        // Random values and strobes on every register
        repeat (40) begin
            k = $unsigned($random(seed)) % 6;
            wreg(k, 16'($random(seed)), 4'($random(seed)) | ((k == 5) ? 4'h1 : 4'h0));
            rreg(k);
        end
        // Step store entries including both index ends
        for (int j = 0; j < 10; j++) begin
            wreg(4, (16'($random(seed)) & 16'hffe0) | ((j < 2) ? 16'(31 * j) : 16'($random(seed))),
                4'h3);
            wreg(5, 16'($random(seed)), 4'h3);
        end
        for (int j = 0; j < 32; j++) begin
            if (stored[j]) begin
                @(posedge i_clk);
                i_step_read_index <= 5'(j);
                @(posedge i_clk);
                @(negedge i_clk);
                chk({17'h0, o_step_read}, {17'h0, exp_store[j]});
            end
        end
        // Unmapped and misaligned places are refused
        apb(1'b1, 32'h0000_0170, 32'hffff_ffff, 4'hf, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        apb(1'b0, 32'h0000_0169, 32'h0000_0000, 4'h0, r, e);
        chk({e, r[30:0]}, 32'h8000_0000);
        apb(1'b1, 32'h0001_0168, 32'hffff_ffff, 4'hf, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        @(negedge i_clk);
        chk_out();
        // Second reset in mid-run clears every register, stage control output and step readback, but not the step store; o_pready stays high
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({17'h0, o_step_read}, 32'h0000_0000);
        i_rst <= 1'b0;
        for (int j = 0; j < 6; j++) exp_reg[j] = oser_pkg::RST_ZERO;
        chk_out();
        for (int j = 0; j < 6; j++) rreg(j);
        summarize();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        err_total++;
        summarize();
    end
endmodule
